// >>> design/trc_glitch_filter.sv
/*
  glitch filter for the command pulse input pin.
  assumes an asynchronous pin; it is synchronised here before any use.
*/
`timescale 1ns/1ns
`default_nettype none
module trc_glitch_filter (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic clear,
  input wire logic [7:0] need,
  // pin and result
  input wire logic pin,
  output logic filt
);

  logic sync1_q; // first sync stage, read only by sync2_q
  logic sync2_q; // second sync stage
  logic filt_q; // accepted level
  logic [7:0] cnt_q; // clocks the new level has been stable
  logic differs; // synced level differs from accepted
  logic accept; // new level stable long enough

  assign differs = sync2_q != filt_q;
  assign accept = differs && ((cnt_q + 8'h01) >= need);
  assign filt = filt_q;

  // two-stage synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= pin;
      sync2_q <= sync1_q;
    end
  end

  // level must hold for need clocks before it passes
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      filt_q <= 1'b0;
      cnt_q <= 8'h00;
    end else if (accept) begin
      filt_q <= sync2_q;
      cnt_q <= 8'h00;
    end else if (differs) begin
      cnt_q <= cnt_q + 8'h01;
    end else begin
      cnt_q <= 8'h00; // glitch dropped
    end
  end

  // a change of the result needs a stable run of need clocks
  property p_filt_stable;
    @(posedge aclk) disable iff (!aresetn)
      (!$past(clear) && $changed(filt_q)) |-> ($past(cnt_q) + 8'h01 >= $past(need));
  endproperty
  a_filt_stable: assert property (p_filt_stable) else $error("filter passed a short level");

endmodule
`default_nettype wire

// >>> design/trc_pkg.sv
/*
  shared constants and types of the torque-reach output conditioning block:
  register offsets, reset values, legal ranges and timing figures.
  assumes a single 50 MHz clock and 32-bit AXI4-Lite register access.
*/
package trc_pkg;

  // clock and time units
  localparam int CLK_PERIOD_NS = 20; // system clock period
  localparam int MS_NS = 1000000; // one millisecond in ns
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS; // clocks per millisecond
  localparam int FILT_UNIT_NS = 10; // filter setting step

  // register byte offsets
  localparam logic [7:0] OFS_POL = 8'h00; // output_polarity_select
  localparam logic [7:0] OFS_THR = 8'h04; // torque_reach_threshold
  localparam logic [7:0] OFS_QT = 8'h08; // torque_reach_qualify_time
  localparam logic [7:0] OFS_FILT = 8'h0C; // pulse_glitch_filter_time
  localparam logic [7:0] OFS_CTRL = 8'h10; // restart control
  localparam logic [7:0] OFS_STAT = 8'h14; // live status

  // field positions
  localparam int CTRL_RESTART_BIT = 0; // write 1 to restart
  localparam int STAT_FLAG_BIT = 0; // torque_reached_flag
  localparam int STAT_PULSE_BIT = 1; // filtered pulse level
  localparam int STAT_POL_LSB = 4; // active polarity digits

  // reset values
  localparam logic [3:0] POL_RST = 4'h0;
  localparam logic [15:0] THR_RST = 16'h0064;
  localparam logic [15:0] QT_RST = 16'h000A;
  localparam logic [15:0] FILT_RST = 16'h0014;

  // legal ranges
  localparam logic [15:0] THR_MIN = 16'h0003;
  localparam logic [15:0] THR_MAX = 16'h012C;
  localparam logic [15:0] QT_MIN = 16'h0001;
  localparam logic [15:0] QT_MAX = 16'h03E8;
  localparam logic [15:0] FILT_MIN = 16'h000A;
  localparam logic [15:0] FILT_MAX = 16'h0064;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // configuration as written by software
  typedef struct packed {
    logic [3:0] pol; // polarity digits, pending until restart
    logic [15:0] thr; // threshold in percent
    logic [15:0] qt; // qualify time in ms
    logic [15:0] filt; // filter time in 10 ns steps
  } trc_cfg_t;

  // clocks a filter setting needs, rounded up, at least one
  function automatic logic [7:0] filt_cycles(input logic [15:0] steps);
    int ns;
    int cyc;
    ns = int'(steps) * FILT_UNIT_NS;
    cyc = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (cyc < 1) begin
      cyc = 1;
    end
    return cyc[7:0];
  endfunction

endpackage

// >>> design/trc_top.sv
/*
  torque-reach output conditioning: output polarity, torque-reached
  detector, pulse input glitch filter and an AXI4-Lite register slave.
  assumes torque_pct and out_raw come from logic on aclk; pulse_pin is
  an asynchronous pin.
*/
`timescale 1ns/1ns
`default_nettype none
module trc_top #(
  parameter int CYC_PER_MS = trc_pkg::CYC_PER_MS // shorten for simulation
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // drive-side signals
  input wire logic [3:0] out_raw,
  input wire logic [15:0] torque_pct,
  input wire logic pulse_pin,
  // conditioned outputs
  output logic [3:0] out_pin,
  output logic torque_reached_flag,
  output logic pulse_filt
);

  localparam int PRE_W = $clog2(CYC_PER_MS + 1); // prescaler width

  // merge byte strobes into a 16-bit field, then clamp to its range
  function automatic logic [15:0] wr_clamp(input logic [15:0] old, input logic [31:0] wd,
                                           input logic [3:0] strb, input logic [15:0] lo,
                                           input logic [15:0] hi);
    logic [15:0] v;
    v = old;
    if (strb[0]) begin
      v[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      v[15:8] = wd[15:8];
    end
    if (v < lo) begin
      v = lo;
    end else if (v > hi) begin
      v = hi;
    end
    return v;
  endfunction

  trc_pkg::trc_cfg_t cfg_q; // software settings
  logic [3:0] act_pol_q; // polarity in use
  logic restart_q; // one-clock restart pulse
  logic [3:0] out_q; // registered output pins
  logic flag_q; // torque reached
  logic [PRE_W-1:0] pre_q; // clocks within current ms
  logic [15:0] ms_q; // whole ms spent above threshold

  // axi write state
  logic awready_q;
  logic wready_q;
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  // axi read state
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // write channel decode
  wire aw_take = s_axi_awvalid && awready_q;
  wire w_take = s_axi_wvalid && wready_q;
  wire do_write = aw_have_q && w_have_q && !bvalid_q;
  wire aw_have_d = (aw_have_q || aw_take) && !do_write;
  wire w_have_d = (w_have_q || w_take) && !do_write;
  wire bvalid_d = do_write || (bvalid_q && !s_axi_bready);
  wire wr_pol = do_write && (awaddr_q[7:2] == trc_pkg::OFS_POL[7:2]);
  wire wr_thr = do_write && (awaddr_q[7:2] == trc_pkg::OFS_THR[7:2]);
  wire wr_qt = do_write && (awaddr_q[7:2] == trc_pkg::OFS_QT[7:2]);
  wire wr_filt = do_write && (awaddr_q[7:2] == trc_pkg::OFS_FILT[7:2]);
  wire wr_ctrl = do_write && (awaddr_q[7:2] == trc_pkg::OFS_CTRL[7:2]);
  wire wr_stat = do_write && (awaddr_q[7:2] == trc_pkg::OFS_STAT[7:2]);
  wire wr_hit = wr_pol || wr_thr || wr_qt || wr_filt || wr_ctrl || wr_stat;
  wire restart_req = wr_ctrl && wstrb_q[0] && wdata_q[trc_pkg::CTRL_RESTART_BIT];

  // read channel decode
  wire ar_take = s_axi_arvalid && arready_q;
  wire rvalid_d = ar_take || (rvalid_q && !s_axi_rready);
  wire [5:0] ra = s_axi_araddr[7:2];
  wire rd_pol = ra == trc_pkg::OFS_POL[7:2];
  wire rd_thr = ra == trc_pkg::OFS_THR[7:2];
  wire rd_qt = ra == trc_pkg::OFS_QT[7:2];
  wire rd_filt = ra == trc_pkg::OFS_FILT[7:2];
  wire rd_ctrl = ra == trc_pkg::OFS_CTRL[7:2];
  wire rd_stat = ra == trc_pkg::OFS_STAT[7:2];
  wire rd_hit = rd_pol || rd_thr || rd_qt || rd_filt || rd_ctrl || rd_stat;
  wire [31:0] stat_word = {24'h000000, act_pol_q, 2'h0, pulse_filt, flag_q};
  wire [31:0] rd_mux = rd_pol ? {28'h0000000, cfg_q.pol} :
                       rd_thr ? {16'h0000, cfg_q.thr} :
                       rd_qt ? {16'h0000, cfg_q.qt} :
                       rd_filt ? {16'h0000, cfg_q.filt} :
                       rd_stat ? stat_word : 32'h00000000;

  // detector decode
  wire above = torque_pct > cfg_q.thr;
  wire pre_wrap = pre_q == PRE_W'(CYC_PER_MS - 1);
  wire ms_sat = ms_q >= trc_pkg::QT_MAX;
  wire qualified = ms_q >= cfg_q.qt;
  wire [7:0] filt_need = trc_pkg::filt_cycles(cfg_q.filt);

  // axi write handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= trc_pkg::RESP_OKAY;
    end else begin
      awready_q <= !aw_have_d && !bvalid_d;
      wready_q <= !w_have_d && !bvalid_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      bvalid_q <= bvalid_d;
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        bresp_q <= wr_hit ? trc_pkg::RESP_OKAY : trc_pkg::RESP_SLVERR;
      end
    end
  end

  // settings, threshold, qualify and filter writes are clamped into range
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q.pol <= trc_pkg::POL_RST;
      cfg_q.thr <= trc_pkg::THR_RST;
      cfg_q.qt <= trc_pkg::QT_RST;
      cfg_q.filt <= trc_pkg::FILT_RST;
    end else begin
      if (wr_pol && wstrb_q[0]) begin
        cfg_q.pol <= wdata_q[3:0]; // pending digits
      end
      if (wr_thr) begin
        cfg_q.thr <= wr_clamp(cfg_q.thr, wdata_q, wstrb_q, trc_pkg::THR_MIN, trc_pkg::THR_MAX);
      end
      if (wr_qt) begin
        cfg_q.qt <= wr_clamp(cfg_q.qt, wdata_q, wstrb_q, trc_pkg::QT_MIN, trc_pkg::QT_MAX);
      end
      if (wr_filt) begin
        cfg_q.filt <= wr_clamp(cfg_q.filt, wdata_q, wstrb_q, trc_pkg::FILT_MIN, trc_pkg::FILT_MAX);
      end
    end
  end

  // restart pulse and polarity in use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      restart_q <= 1'b0;
      act_pol_q <= trc_pkg::POL_RST;
    end else begin
      restart_q <= restart_req;
      if (restart_q) begin
        act_pol_q <= cfg_q.pol;
      end
    end
  end

  // axi read handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= trc_pkg::RESP_OKAY;
    end else begin
      arready_q <= !rvalid_d;
      rvalid_q <= rvalid_d;
      if (ar_take) begin
        rdata_q <= rd_mux;
        rresp_q <= rd_hit ? trc_pkg::RESP_OKAY : trc_pkg::RESP_SLVERR;
      end
    end
  end

  // output pairs with selected polarity
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_q <= 4'h0;
    end else begin
      out_q <= out_raw ^ act_pol_q;
    end
  end

  // time spent above threshold, cleared on any drop
  always_ff @(posedge aclk) begin
    if (!aresetn || restart_q || !above) begin
      pre_q <= '0;
      ms_q <= 16'h0000;
    end else if (pre_wrap) begin
      pre_q <= '0;
      if (!ms_sat) begin
        ms_q <= ms_q + 16'h0001;
      end
    end else begin
      pre_q <= pre_q + PRE_W'(1);
    end
  end

  // flag set one clock after the full time, so strictly longer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= above && !restart_q && qualified;
    end
  end

  // command pulse glitch filter
  trc_glitch_filter trc_glitch_filter_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(restart_q),
    .need(filt_need),
    .pin(pulse_pin),
    .filt(pulse_filt)
  );

  // port drive
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign out_pin = out_q;
  assign torque_reached_flag = flag_q;

  // checks
  sequence s_restart;
    restart_q;
  endsequence

  property p_pol_hold;
    @(posedge aclk) disable iff (!aresetn)
      !$past(restart_q) |-> $stable(act_pol_q);
  endproperty
  a_pol_hold: assert property (p_pol_hold) else $error("polarity changed without restart");

  property p_pol_load;
    @(posedge aclk) disable iff (!aresetn)
      s_restart |=> act_pol_q == $past(cfg_q.pol);
  endproperty
  a_pol_load: assert property (p_pol_load) else $error("restart did not load polarity");

  property p_pol_out;
    @(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> out_q == ($past(out_raw) ^ $past(act_pol_q));
  endproperty
  a_pol_out: assert property (p_pol_out) else $error("output polarity wrong");

  property p_flag_cause;
    @(posedge aclk) disable iff (!aresetn)
      flag_q |-> $past(above) && ($past(ms_q) >= $past(cfg_q.qt)) && $past(cfg_q.qt) >= trc_pkg::QT_MIN;
  endproperty
  a_flag_cause: assert property (p_flag_cause) else $error("flag without qualified time");

  property p_flag_drop;
    @(posedge aclk) disable iff (!aresetn)
      !above |=> !flag_q;
  endproperty
  a_flag_drop: assert property (p_flag_drop) else $error("flag held after torque dropped");

  property p_thr_range;
    @(posedge aclk) disable iff (!aresetn)
      wr_thr |=> cfg_q.thr >= trc_pkg::THR_MIN && cfg_q.thr <= trc_pkg::THR_MAX;
  endproperty
  a_thr_range: assert property (p_thr_range) else $error("threshold out of range");

  property p_qt_range;
    @(posedge aclk) disable iff (!aresetn)
      wr_qt |=> cfg_q.qt >= trc_pkg::QT_MIN && cfg_q.qt <= trc_pkg::QT_MAX;
  endproperty
  a_qt_range: assert property (p_qt_range) else $error("qualify time out of range");

  property p_filt_range;
    @(posedge aclk) disable iff (!aresetn)
      wr_filt |=> cfg_q.filt >= trc_pkg::FILT_MIN && cfg_q.filt <= trc_pkg::FILT_MAX;
  endproperty
  a_filt_range: assert property (p_filt_range) else $error("filter time out of range");

  property p_bvalid_hold;
    @(posedge aclk) disable iff (!aresetn)
      bvalid_q && !s_axi_bready |=> bvalid_q && $stable(bresp_q);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped early");

endmodule
`default_nettype wire

// >>> verif/torque_reach_output_conditioning_bench.sv
/*
  self-checking bench for trc_top with a host model on the pulse link.
  assumes a short millisecond (10 clocks) so detector times stay small.
*/
`timescale 1ns/1ns
`default_nettype none
module torque_reach_output_conditioning_bench;
  localparam logic [1:0] OK = 2'h0; // okay response
  localparam logic [1:0] ERR = 2'h2; // unmapped response
  // clock, reset and bus
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h3;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  // drive side
  logic [3:0] out_raw = 4'h0;
  logic [15:0] torque_pct = 16'h0;
  logic pulse_pin, flag, pulse_filt;
  logic [3:0] out_pin;
  logic [7:0] rise_cnt;
  // expectations and bookkeeping
  logic [1:0] wq[$];
  logic [33:0] rq[$];
  int err_count = 0;
  int n_compared = 0;
  logic [3:0] pol, raw;
  // clamp table: address, written, read back
  logic [7:0] ca[6] = '{8'h04, 8'h04, 8'h08, 8'h08, 8'h0C, 8'h0C};
  logic [31:0] cw[6] = '{32'h1, 32'h1F4, 32'h0, 32'h7D0, 32'h5, 32'hC8};
  logic [31:0] cr[6] = '{32'h3, 32'h12C, 32'h1, 32'h3E8, 32'hA, 32'h64};

  always #10 aclk = ~aclk;

  trc_top #(.CYC_PER_MS(10)) trc_top_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .out_raw(out_raw), .torque_pct(torque_pct), .pulse_pin(pulse_pin),
    .out_pin(out_pin), .torque_reached_flag(flag), .pulse_filt(pulse_filt)
  );

  trc_host_model trc_host_model_i (
    .aclk(aclk), .pulse_filt(pulse_filt), .pulse_pin(pulse_pin), .rise_cnt(rise_cnt)
  );

  // verdict and end of run
  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // single comparison point
  task automatic check(input logic [33:0] s, input logic [33:0] e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, s, e);
    end
  endtask

  // a wait that ran out
  task automatic stuck;
    err_count++;
    $display("Error at %0t: wait ran out", $time);
    end_of_test();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // register write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    wq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 40);
    if (!bvalid) stuck();
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  // register read
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    rq.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 40);
    if (!rvalid) stuck();
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // settled level check: 0 out_pin, 1 flag, 2 filtered pulse, 3 pulse count
  task automatic lvl(input int sel, input logic [3:0] e);
    logic [3:0] s;
    @(negedge aclk);
    s = sel == 0 ? out_pin : sel == 1 ? {3'h0, flag} : sel == 2 ? {3'h0, pulse_filt} : rise_cnt[3:0];
    check(34'(s), 34'(e));
    @(posedge aclk);
  endtask

  // bus answers are compared against the oldest note
  always @(posedge aclk) begin
    if (bvalid && bready) begin
      check(34'(bresp), 34'(wq.pop_front()));
    end
    if (rvalid && rready) begin
      check({rresp, rdata}, rq.pop_front());
    end
  end

  initial begin
    void'($urandom(32'hd50d));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(2);
    // reset values and an unmapped place
    rd(8'h00, 32'h0, OK);
    rd(8'h04, 32'h64, OK);
    rd(8'h08, 32'hA, OK);
    rd(8'h0C, 32'h14, OK);
    rd(8'h18, 32'h0, ERR);
    wr(8'h18, 32'h5, ERR);
    wr(8'h14, 32'hF, OK);
    rd(8'h10, 32'h0, OK);
    $display("test reset values done");
    // range limits of each setting
    for (int i = 0; i < 6; i++) begin
      wr(ca[i], cw[i], OK);
      rd(ca[i], cr[i], OK);
    end
    $display("test ranges done");
    // polarity waits for restart, then inverts its pairs
    pol = 4'($urandom()) | 4'h1;
    raw = 4'($urandom());
    out_raw <= raw;
    wr(8'h00, {28'h0, pol}, OK);
    lvl(0, raw);
    rd(8'h14, 32'h0, OK);
    wr(8'h10, 32'h1, OK);
    cyc(3);
    lvl(0, raw ^ pol);
    rd(8'h14, {24'h0, pol, 4'h0}, OK);
    for (int i = 0; i < 4; i++) begin
      raw = 4'($urandom());
      out_raw <= raw;
      cyc(1);
      lvl(0, raw ^ pol);
    end
    $display("test polarity done");
    // torque reached: 1 ms of 10 clocks, threshold 50
    wr(8'h04, 32'h32, OK);
    wr(8'h08, 32'h1, OK);
    torque_pct <= 16'h33;
    cyc(10);
    lvl(1, 4'h0);
    cyc(2);
    lvl(1, 4'h1);
    wr(8'h04, 32'h3C, OK);
    cyc(2);
    lvl(1, 4'h0);
    torque_pct <= 16'h3C;
    cyc(30);
    lvl(1, 4'h0);
    for (int i = 0; i < 2; i++) begin
      torque_pct <= 16'h3D;
      cyc(8);
      torque_pct <= 16'h0;
      cyc(1);
    end
    lvl(1, 4'h0);
    wr(8'h08, 32'h2, OK);
    torque_pct <= 16'h3D;
    cyc(15);
    lvl(1, 4'h0);
    cyc(8);
    lvl(1, 4'h1);
    torque_pct <= 16'h0;
    $display("test torque reached done");
    // pulse filter at 200 ns and then 100 ns
    wr(8'h0C, 32'h14, OK);
    trc_host_model_i.pulse(8);
    lvl(3, 4'h0);
    trc_host_model_i.pulse(12);
    lvl(3, 4'h1);
    wr(8'h0C, 32'hA, OK);
    trc_host_model_i.pulse(4);
    lvl(3, 4'h1);
    trc_host_model_i.pulse(6);
    lvl(3, 4'h2);
    lvl(2, 4'h0);
    $display("test pulse filter done");
    end_of_test();
  end
endmodule
`default_nettype wire

// >>> verif/trc_host_model.sv
/*
  host motion controller model: sends command pulses of a set width and
  counts the pulses that the drive's filter lets through.
  assumes pulse calls come from the bench right after a rising edge of aclk.
*/
`timescale 1ns/1ns
`default_nettype none
module trc_host_model (
  // clock
  input wire logic aclk,
  // pulse link
  input wire logic pulse_filt,
  output wire logic pulse_pin,
  // observation
  output wire logic [7:0] rise_cnt
);
  logic last_q = 1'b0; // filtered level one edge ago
  logic pin_q = 1'b0; // level driven onto the pulse pin
  logic [7:0] cnt_q = 8'h00; // pulses the drive accepted

  assign pulse_pin = pin_q;
  assign rise_cnt = cnt_q;

  // count every pulse that the drive accepted
  always @(posedge aclk) begin
    last_q <= pulse_filt;
    if (pulse_filt && !last_q) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // one high pulse of w clocks, then a long quiet gap
  task automatic pulse(input int w);
    @(posedge aclk);
    pin_q <= 1'b1;
    repeat (w) @(posedge aclk);
    pin_q <= 1'b0;
    repeat (30) @(posedge aclk);
  endtask
endmodule
`default_nettype wire
